// ---- verilog/ssf_fifo_ctrl.sv ----
`timescale 1ns/10ps
module ssf_fifo_ctrl
  import ssf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register access port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  output logic [7:0] regRdData,
  output logic regRdValid,
  // Sample stream and acquisition tick
  input wire logic sampleValid,
  input wire logic [SAMPLE_WIDTH-1:0] sampleData,
  output logic sampleReady,
  input wire logic acqTick,
  // System mode and FIFO event
  input wire logic activeMode,
  output logic fifoIntSource
);

  ssf_ctrl_s st;
  ssf_ctrl_s next_st;
  logic [SAMPLE_WIDTH-1:0] sampleMem [DEPTH];
  logic memWr;
  logic popNow;
  logic [SAMPLE_WIDTH-1:0] head;
  logic [1:0] newMode;

  ssf_smp_if smp ();

  // ==========================================================
  // Input buffer
  ssf_skid_buf u_buf (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .inValid(sampleValid),
    .inData(sampleData),
    .inReady(sampleReady),
    .outPort(smp)
  );

  // Pointer step with wrap at the depth
  function automatic logic [4:0] ptrInc(input logic [4:0] p);
    ptrInc = (p == 5'(DEPTH - 1)) ? 5'h00 : p + 5'h01;
  endfunction

  // Byte of the head sample, first byte the most significant
  function automatic logic [7:0] headByte(input logic [SAMPLE_WIDTH-1:0] s,
                                          input logic [2:0] i);
    headByte = s[SAMPLE_WIDTH - 1 - 8 * i -: 8];
  endfunction

  assign head = sampleMem[st.rdPtr];
  // The store is single ported per cycle: a pop stalls the stream
  assign popNow = regRdEn && (regAddr == ADDR_FIFO_DATA) && (st.count != 6'h00)
                  && (st.byteIdx == 3'(SAMPLE_BYTES - 1));
  assign smp.ready = !popNow;
  assign newMode = regWrData[SETUP_MODE_LSB +: 2];

  // ==========================================================
  // Control state update
  always_comb
  begin
    next_st = st;
    memWr = 1'b0;
    next_st.rdValid = regRdEn;
    next_st.prevActive = activeMode;
    next_st.sysMode = activeMode;

    // Setup writes, accepted whatever the system mode
    if (regWrEn && (regAddr == ADDR_FIFO_SETUP))
    begin
      next_st.wmrkLevel = regWrData[SETUP_WMRK_LSB +: 6];
      if (newMode == MODE_DISABLED || st.mode == MODE_DISABLED)
      begin
        if (newMode != MODE_UNUSED)
        begin
          next_st.mode = newMode;
        end
      end
      // else: direct 01/10 swap keeps the old mode
    end

    // Reads: data port pops, status read clears the event source
    if (regRdEn)
    begin
      unique case (regAddr)
        ADDR_FIFO_STATUS:
        begin
          next_st.rdData = {st.overflowFlag, st.wmrkHitFlag, st.count};
          next_st.intSource = 1'b0;
        end
        ADDR_FIFO_DATA:
        begin
          next_st.rdData = RESET_READ_DATA;
          if (st.count != 6'h00)
          begin
            next_st.rdData = headByte(head, st.byteIdx);
            if (popNow)
            begin
              next_st.byteIdx = 3'h0;
              next_st.rdPtr = ptrInc(st.rdPtr);
              next_st.count = st.count - 6'h01;
            end
            else
            begin
              next_st.byteIdx = st.byteIdx + 3'h1;
            end
          end
        end
        ADDR_FIFO_SETUP: next_st.rdData = {st.mode, st.wmrkLevel};
        ADDR_ELAPSED_TICKS: next_st.rdData = st.ticks;
        ADDR_SYSTEM_MODE: next_st.rdData = {7'h00, st.sysMode};
        default: next_st.rdData = RESET_READ_DATA;
      endcase
    end

    // Sample intake; the watermark never throttles it
    if (smp.valid && smp.ready)
    begin
      if (st.mode == MODE_CIRCULAR || st.mode == MODE_STOP)
      begin
        if (st.count != 6'(DEPTH))
        begin
          memWr = 1'b1;
          next_st.wrPtr = ptrInc(st.wrPtr);
          next_st.count = st.count + 6'h01;
        end
        else if (st.mode == MODE_CIRCULAR)
        begin
          memWr = 1'b1;
          next_st.wrPtr = ptrInc(st.wrPtr);
          next_st.rdPtr = ptrInc(st.rdPtr);
          next_st.byteIdx = 3'h0;
        end
        // Stop mode at full: sample dropped, contents kept
      end
    end

    // Elapsed ticks: start at overflow, saturate, clear when emptied
    if (st.tickRun && acqTick && st.ticks != 8'hff)
    begin
      next_st.ticks = st.ticks + 8'h01;
    end
    if (next_st.count == 6'(DEPTH))
    begin
      next_st.tickRun = 1'b1;
    end
    if (popNow && st.count == 6'h01)
    begin
      next_st.tickRun = 1'b0;
      next_st.ticks = RESET_TICKS;
    end

    // Flush when disabled or on entry to active mode
    if (next_st.mode == MODE_DISABLED || (activeMode && !st.prevActive))
    begin
      memWr = 1'b0;
      next_st.wrPtr = 5'h00;
      next_st.rdPtr = 5'h00;
      next_st.count = 6'h00;
      next_st.byteIdx = 3'h0;
      next_st.tickRun = 1'b0;
      next_st.ticks = RESET_TICKS;
    end

    // Flags follow the count; level zero never matches
    next_st.overflowFlag = (next_st.count == 6'(DEPTH));
    next_st.wmrkHitFlag = (next_st.wmrkLevel != RESET_WMRK)
                          && (next_st.count == next_st.wmrkLevel);
    // Rising event sets the source bit; set wins over a same-cycle clear
    if ((next_st.overflowFlag && !st.overflowFlag)
        || (next_st.wmrkHitFlag && !st.wmrkHitFlag))
    begin
      next_st.intSource = 1'b1;
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  // Sample storage, no reset needed since the count guards it
  always_ff @(posedge ref_clk)
  begin
    if (memWr)
    begin
      sampleMem[st.wrPtr] <= smp.data;
    end
  end

  assign regRdData = st.rdData;
  assign regRdValid = st.rdValid;
  assign fifoIntSource = st.intSource;

endmodule // ssf_fifo_ctrl

// ---- verilog/ssf_pkg.sv ----
package ssf_pkg;

  // ==========================================================
  // Register offsets
  localparam logic [7:0] ADDR_FIFO_STATUS = 8'h0d;
  localparam logic [7:0] ADDR_FIFO_DATA = 8'h0e;
  localparam logic [7:0] ADDR_FIFO_SETUP = 8'h0f;
  localparam logic [7:0] ADDR_ELAPSED_TICKS = 8'h10;
  localparam logic [7:0] ADDR_SYSTEM_MODE = 8'h11;

  // ==========================================================
  // Field positions
  localparam int SETUP_MODE_LSB = 6;
  localparam int SETUP_WMRK_LSB = 0;
  localparam int STATUS_OVF_BIT = 7;
  localparam int STATUS_WMRK_BIT = 6;
  localparam int STATUS_CNT_LSB = 0;

  // ==========================================================
  // Overflow modes
  localparam logic [1:0] MODE_DISABLED = 2'h0;
  localparam logic [1:0] MODE_CIRCULAR = 2'h1;
  localparam logic [1:0] MODE_STOP = 2'h2;
  localparam logic [1:0] MODE_UNUSED = 2'h3;

  // ==========================================================
  // Reset values and sizes
  localparam logic [1:0] RESET_MODE = 2'h0;
  localparam logic [5:0] RESET_WMRK = 6'h00;
  localparam logic [7:0] RESET_TICKS = 8'h00;
  localparam logic [7:0] RESET_READ_DATA = 8'h00;
  localparam int FIFO_DEPTH = 32;
  localparam int SAMPLE_BYTES = 5;
  localparam int SAMPLE_WIDTH = 8 * SAMPLE_BYTES;

  // ==========================================================
  // State of the control block
  typedef struct packed {
    logic [1:0] mode;
    logic [5:0] wmrkLevel;
    logic [4:0] wrPtr;
    logic [4:0] rdPtr;
    logic [5:0] count;
    logic [2:0] byteIdx;
    logic overflowFlag;
    logic wmrkHitFlag;
    logic tickRun;
    logic [7:0] ticks;
    logic intSource;
    logic prevActive;
    logic sysMode;
    logic [7:0] rdData;
    logic rdValid;
  } ssf_ctrl_s;

  // State of the two-entry buffer
  typedef struct packed {
    logic [SAMPLE_WIDTH-1:0] entry0;
    logic [SAMPLE_WIDTH-1:0] entry1;
    logic [1:0] fill;
    logic inReady;
  } ssf_buf_s;

endpackage

// ---- verilog/ssf_smp_if.sv ----
`timescale 1ns/10ps
// Sample stream from the buffer into the FIFO store
interface ssf_smp_if;
  import ssf_pkg::*;
  logic valid;
  logic ready;
  logic [SAMPLE_WIDTH-1:0] data;
  modport src (output valid, output data, input ready);
  modport dst (input valid, input data, output ready);
endinterface

// ---- verilog/ssf_skid_buf.sv ----
`timescale 1ns/10ps
// ==========================================================
// Two-entry buffer: a stall by the store loses no sample
module ssf_skid_buf
  import ssf_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Upstream
  input wire logic inValid,
  input wire logic [SAMPLE_WIDTH-1:0] inData,
  output logic inReady,
  // Downstream
  ssf_smp_if.src outPort
);

  ssf_buf_s st;
  ssf_buf_s next_st;
  logic push;
  logic pop;

  // Head entry drives the stream
  assign outPort.valid = (st.fill != 2'h0);
  assign outPort.data = st.entry0;

  // Shift-register update; ready is registered from the next fill
  always_comb
  begin
    next_st = st;
    push = inValid && st.inReady;
    pop = outPort.valid && outPort.ready;
    if (pop)
    begin
      next_st.entry0 = st.entry1;
      next_st.fill = st.fill - 2'h1;
    end
    if (push)
    begin
      if (next_st.fill == 2'h0)
      begin
        next_st.entry0 = inData;
      end
      else
      begin
        next_st.entry1 = inData;
      end
      next_st.fill = next_st.fill + 2'h1;
    end
    next_st.inReady = (next_st.fill != 2'h2);
  end

  always_ff @(posedge ref_clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      st <= '0;
    end
    else
    begin
      st <= next_st;
    end
  end

  assign inReady = st.inReady;

endmodule // ssf_skid_buf

// ---- dv/ssf_fifo_ctrl_properties.sv ----
`timescale 1ns/10ps
// ==========================================================
// Port checker for the FIFO control block
module ssf_fifo_ctrl_chk
  import ssf_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
)
(
  // Clock and reset
  input wire logic ref_clk,
  input wire logic rst_b,
  // Register port
  input wire logic regWrEn,
  input wire logic regRdEn,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic [7:0] regRdData,
  input wire logic regRdValid,
  input wire logic fifoIntSource
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  // Decoded requests, a cycle ahead of the answer
  wire logic rdStat = regRdEn && regAddr == ADDR_FIFO_STATUS;
  wire logic rdSetup = regRdEn && regAddr == ADDR_FIFO_SETUP;
  wire logic rdSys = regRdEn && regAddr == ADDR_SYSTEM_MODE;
  wire logic wrDis = regWrEn && regAddr == ADDR_FIFO_SETUP && regWrData[7:6] == MODE_DISABLED;
  wire logic rdOff = regRdEn && (regAddr < ADDR_FIFO_STATUS || regAddr > ADDR_SYSTEM_MODE);
  // ==========================================================
  // Assertions
  chk_read_answer: assert property (regRdEn |=> regRdValid)
    else $error("read got no answer");
  chk_answer_cause: assert property (regRdValid |-> $past(regRdEn))
    else $error("answer without read");
  chk_sysmode_pad: assert property (rdSys |=> regRdData[7:1] == 7'h00)
    else $error("mode register pad bits set");
  chk_ovf_full: assert property (rdStat |=> regRdData[7] == (regRdData[5:0] == 6'h20))
    else $error("overflow flag disagrees with count");
  chk_count_bound: assert property (rdStat |=> regRdData[5:0] <= 6'(DEPTH))
    else $error("count above depth");
  chk_mode_legal: assert property (rdSetup |=> regRdData[7:6] != MODE_UNUSED)
    else $error("unused mode stored");
  chk_wmrk_nonzero: assert property (rdStat |=> !regRdData[6] || (|regRdData[5:0]))
    else $error("watermark flag on empty fifo");
  chk_disable_echo: assert property (wrDis ##2 rdSetup |=>
    regRdData == $past(regWrData, 3))
    else $error("disable write not taken");
  chk_unmapped_zero: assert property (rdOff |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  // Main scenarios reached
  cover property (rdStat ##1 regRdData[7]);
  cover property (wrDis);
  cover property (fifoIntSource && rdStat);
endmodule // ssf_fifo_ctrl_chk

bind ssf_fifo_ctrl ssf_fifo_ctrl_chk #(.DEPTH(DEPTH)) u_chk (.ref_clk, .rst_b, .regWrEn, .regRdEn,
  .regAddr, .regWrData, .regRdData, .regRdValid, .fifoIntSource);

// ---- dv/ssf_sample_src.sv ----
`timescale 1ns/10ps
// ==========================================================
// Sample source: offers a word and holds it until taken
module ssf_sample_src
  import ssf_pkg::*;
(
  // Clock
  input wire logic ref_clk,
  // Stream
  output logic sampleValid,
  output logic [SAMPLE_WIDTH-1:0] sampleData,
  input wire logic sampleReady
);
  // Idle at time zero
  initial
  begin
    sampleValid = 1'b0;
    sampleData = '0;
  end
  // All five bytes equal, so any byte read names the sample
  task automatic send(input logic [7:0] n);
    @(negedge ref_clk);
    sampleValid = 1'b1;
    sampleData = {SAMPLE_BYTES{n}};
    // Ready is judged between edges, where it has settled; taken at the next rise
    while (sampleReady !== 1'b1)
      @(negedge ref_clk);
    @(posedge ref_clk);
    @(negedge ref_clk);
    sampleValid = 1'b0;
    sampleData = ~sampleData; // Stale word must not pass as new
  endtask
endmodule // ssf_sample_src

// ---- dv/ssf_fifo_ctrl_tb.sv ----
`timescale 1ns/10ps
// ==========================================================
// Bench for the FIFO control block
module ssf_fifo_ctrl_tb;
  import ssf_pkg::*;
  logic ref_clk, rst_b, regWrEn, regRdEn, acqTick, activeMode;
  logic regRdValid, sampleValid, sampleReady, fifoIntSource;
  logic [7:0] regAddr, regWrData, regRdData;
  logic [SAMPLE_WIDTH-1:0] sampleData;
  int miscompares, checked, cycles;

  ssf_fifo_ctrl i_dut (.ref_clk, .rst_b, .regWrEn, .regRdEn, .regAddr, .regWrData, .regRdData,
    .regRdValid, .sampleValid, .sampleData, .sampleReady, .acqTick, .activeMode, .fifoIntSource);
  ssf_sample_src u_src (.ref_clk, .sampleValid, .sampleData, .sampleReady);

  // Clock; a hang counts as a mismatch
  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      close_out();
    end
  end
  // ==========================================================
  // Tasks
  task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp)
    begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(negedge ref_clk);
    regWrEn = 1'b1;
    regAddr = a;
    regWrData = d;
    @(negedge ref_clk);
    regWrEn = 1'b0;
  endtask
  // Answer stands one cycle, so it is sampled at the next falling edge
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(negedge ref_clk);
    regRdEn = 1'b1;
    regAddr = a;
    @(negedge ref_clk);
    regRdEn = 1'b0;
    chk("regRdValid", 8'h01, {7'h00, regRdValid});
    chk($sformatf("reg %h", a), exp, regRdData);
  endtask
  // Samples need a few cycles through the buffer before they count
  task automatic push(input int first, input int n);
    for (int i = 0; i < n; i++)
      u_src.send(8'(first + i));
    repeat (4) @(negedge ref_clk);
  endtask
  task automatic tick(input int n);
    repeat (n)
    begin
      @(negedge ref_clk);
      acqTick = 1'b1;
      @(negedge ref_clk);
      acqTick = 1'b0;
    end
  endtask
  task automatic close_out();
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // ==========================================================
  // Main sequence
  initial
  begin
    {rst_b, regWrEn, regRdEn, regAddr, regWrData, acqTick, activeMode} = '0;
    repeat (5) @(negedge ref_clk);
    rst_b = 1'b1;
    rd(ADDR_FIFO_SETUP, 8'h00);
    chk("sampleReady", 8'h01, {7'h00, sampleReady});
    rd(ADDR_ELAPSED_TICKS, 8'h00);
    rd(ADDR_SYSTEM_MODE, 8'h00);
    wr(ADDR_FIFO_SETUP, 8'h42);
    activeMode = 1'b1;
    rd(ADDR_SYSTEM_MODE, 8'h01);
    rd(ADDR_FIFO_SETUP, 8'h42);
    wr(ADDR_FIFO_SETUP, 8'h82);
    rd(ADDR_FIFO_SETUP, 8'h42);
    wr(ADDR_FIFO_SETUP, 8'hc2);
    rd(ADDR_FIFO_SETUP, 8'h42);
    push(0, 2);
    chk("fifoIntSource", 8'h01, {7'h00, fifoIntSource});
    rd(ADDR_FIFO_STATUS, 8'h42);
    push(2, 30);
    chk("fifoIntSource", 8'h01, {7'h00, fifoIntSource});
    rd(ADDR_FIFO_STATUS, 8'ha0);
    chk("fifoIntSource", 8'h00, {7'h00, fifoIntSource});
    push(32, 1);
    rd(ADDR_FIFO_STATUS, 8'ha0);
    tick(3);
    rd(ADDR_ELAPSED_TICKS, 8'h03);
    repeat (5) rd(ADDR_FIFO_DATA, 8'h01);
    rd(ADDR_FIFO_STATUS, 8'h1f);
    wr(ADDR_FIFO_SETUP, 8'h00);
    rd(ADDR_FIFO_SETUP, 8'h00);
    // Samples offered while disabled are taken and thrown away
    push(96, 2);
    rd(ADDR_FIFO_STATUS, 8'h00);
    rd(ADDR_ELAPSED_TICKS, 8'h00);
    wr(ADDR_FIFO_SETUP, 8'h82);
    push(64, 33);
    rd(ADDR_FIFO_STATUS, 8'ha0);
    rd(ADDR_FIFO_DATA, 8'h40);
    activeMode = 1'b0;
    rd(ADDR_SYSTEM_MODE, 8'h00);
    activeMode = 1'b1;
    rd(ADDR_FIFO_STATUS, 8'h00);
    // Fill, let ticks run, then drain: the last pop clears the ticks
    push(112, 32);
    tick(1);
    rd(ADDR_ELAPSED_TICKS, 8'h01);
    for (int i = 0; i < 32; i++)
      repeat (5) rd(ADDR_FIFO_DATA, 8'(112 + i));
    rd(ADDR_ELAPSED_TICKS, 8'h00);
    rd(ADDR_FIFO_STATUS, 8'h00);
    rd(8'h20, 8'h00);
    close_out();
  end
endmodule // ssf_fifo_ctrl_tb
